/* File: verilog/psu_consts.svh */
// constants for the program segment store and upload block
// Function
// - save command copies the queue into slot one to twelve
// - a save to slot one to twelve ends a host queue load session
// - upload location one to twelve picks a slot, zero the live queue
// - good upload sends ack, header line, then each line ended by carriage return
// - header repeats the upload name and line count plus one
// - empty location answers ack and upload name with code zero
// - running program refuses upload with code minus one
// - upload in progress refuses another upload with code minus two
// - password protection refuses upload with code minus three
// - command not understood answers with the question mark instead
// - load and execute copies slot one to twelve into the queue
// - load and execute then starts the queue at line one
// - load and execute is also taken from a running stored program
// - host queue load lasts until a save to slot one to twelve or a queue execute command
// - starting a queue load overwrites the queue from line one
`ifndef PSU_CONSTS_SVH
`define PSU_CONSTS_SVH

`define PSU_SLOTS 12
`define PSU_LINES 62
`define PSU_LAST_LINE 6'h3D
`define PSU_FIFO_DEPTH 8
`define PSU_EXEC_LINE 6'h01

`define PSU_CHAR_ACK 8'h25
`define PSU_CHAR_NACK 8'h3F
`define PSU_CHAR_CR 8'h0D
`define PSU_CHAR_Q 8'h51
`define PSU_CHAR_U 8'h55
`define PSU_CHAR_MINUS 8'h2D
`define PSU_CHAR_ZERO 8'h30

`define PSU_CMD_QUEUE_LOAD 3'h1
`define PSU_CMD_QUEUE_SAVE 3'h2
`define PSU_CMD_UPLOAD 3'h3
`define PSU_CMD_LOAD_EXEC 3'h4
`define PSU_CMD_QUEUE_EXEC 3'h5

`endif

/* File: verilog/psu_pkg.sv */
// types for the program segment store and upload block
`default_nettype none
package psu_pkg;
   typedef enum logic [4:0] {
      PSU_IDLE = 5'b00001,
      PSU_COPY = 5'b00010,
      PSU_MSG = 5'b00100,
      PSU_BODY = 5'b01000,
      PSU_DONE = 5'b10000
   } psu_state_t;
endpackage
`default_nettype wire

/* File: verilog/psu_top.sv */
// segment store, queue load and text upload logic with its reply fifo
`include "psu_consts.svh"
`default_nettype none

module psu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic ce_i, // clock enable
   input wire logic in_valid_i, // write request
   output logic in_ready_o, // room left
   input wire logic [WIDTH-1:0] in_data_i, // write word
   output logic out_valid_o, // word available
   input wire logic out_ready_i, // reader takes word
   output logic [WIDTH-1:0] out_data_o // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o & ce_i;
   assign pop = out_valid_o & out_ready_i & ce_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // psu_fifo

module psu_top
   import psu_pkg::*;
(
   input wire logic ref_clk_i, // 200 MHz clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic ce_i, // clock enable, freezes all state when low
   input wire logic cmd_valid_i, // decoded command present
   output logic cmd_ready_o, // command taken this cycle
   input wire logic [2:0] cmd_code_i, // command code
   input wire logic cmd_has_param_i, // location parameter given
   input wire logic [7:0] cmd_param_i, // location parameter, signed
   input wire logic line_valid_i, // one queue line from host
   input wire logic [31:0] line_data_i, // line text, four chars, msb first
   input wire logic prog_running_i, // stored program executing
   input wire logic protect_i, // stored programs locked by password
   output logic tx_valid_o, // reply char ready
   input wire logic tx_ready_i, // serial port takes char
   output logic [7:0] tx_data_o, // reply char
   output logic load_active_o, // host queue load session open
   output logic exec_start_o, // pulse: start queue execution
   output logic [5:0] exec_line_o // line to start from
);
   psu_state_t state_q;
   logic [31:0] slot_mem_q [0:`PSU_SLOTS-1][0:`PSU_LINES-1];
   logic [31:0] q_mem_q [0:`PSU_LINES-1];
   logic [5:0] slot_len_q [0:`PSU_SLOTS-1];
   logic [5:0] q_len_q;
   logic load_active_q;
   logic [5:0] load_ptr_q;
   logic [5:0] cp_q;
   logic [3:0] cp_slot_q;
   logic cp_save_q;
   logic cp_exec_q;
   logic [47:0] msg_q;
   logic [2:0] msg_len_q;
   logic body_after_q;
   logic [3:0] up_sel_q;
   logic [5:0] up_len_q;
   logic [5:0] ln_q;
   logic [2:0] bi_q;
   logic pend_busy_q;
   logic exec_start_q;
   logic [5:0] exec_line_q;

   logic cmd_take;
   logic param_ok;
   logic [3:0] slot_idx;
   logic [5:0] sel_len;
   logic [6:0] hdr_n;
   logic [31:0] body_word;
   logic [7:0] body_byte;
   logic [7:0] emit_byte;
   logic emit_valid;
   logic fifo_ready;
   logic emit_go;
   logic body_end;

   function automatic logic [47:0] err_msg(input logic [7:0] digit);
      err_msg = {`PSU_CHAR_ACK, `PSU_CHAR_Q, `PSU_CHAR_U, `PSU_CHAR_MINUS, digit, `PSU_CHAR_CR};
   endfunction

   // only upload commands are taken during an upload, so their refusal can queue up
   assign cmd_ready_o = (state_q == PSU_IDLE)
      | (((state_q == PSU_MSG) | (state_q == PSU_BODY)) & body_after_q & !pend_busy_q
         & (cmd_code_i == `PSU_CMD_UPLOAD));
   assign cmd_take = cmd_valid_i & cmd_ready_o & ce_i;
   assign param_ok = cmd_has_param_i & ($signed(cmd_param_i) >= 8'sh01)
      & ($signed(cmd_param_i) <= 8'sh0C);
   assign slot_idx = cmd_param_i[3:0] - 4'h1;
   assign sel_len = (cmd_param_i == 8'h00) ? q_len_q : slot_len_q[slot_idx];
   assign hdr_n = {1'b0, sel_len} + 7'h01;

   assign body_word = (up_sel_q == 4'h0) ? q_mem_q[ln_q] : slot_mem_q[up_sel_q - 4'h1][ln_q];
   assign body_byte = (bi_q == 3'h4) ? `PSU_CHAR_CR
      : body_word[5'(31 - 8 * bi_q) -: 8];
   assign emit_byte = (state_q == PSU_MSG) ? msg_q[47:40] : body_byte;
   // short lines are padded with zero bytes, which are never sent
   assign emit_valid = (state_q == PSU_MSG) | ((state_q == PSU_BODY) & (body_byte != 8'h00));
   assign emit_go = ((state_q == PSU_MSG) & fifo_ready)
      | ((state_q == PSU_BODY) & (fifo_ready | (body_byte == 8'h00)));
   assign body_end = (bi_q == 3'h4) & (ln_q == up_len_q - 6'h01);

   psu_fifo #(
      .WIDTH(8),
      .DEPTH(`PSU_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_valid_i(emit_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(emit_byte),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );

   // sequencer: copies, reply messages and upload body
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= PSU_IDLE;
         cp_q <= '0;
         cp_slot_q <= '0;
         cp_save_q <= 1'b0;
         cp_exec_q <= 1'b0;
         msg_q <= '0;
         msg_len_q <= '0;
         body_after_q <= 1'b0;
         up_sel_q <= '0;
         up_len_q <= '0;
         ln_q <= '0;
         bi_q <= '0;
      end
      else if (ce_i)
      begin
         unique case (state_q)
            PSU_IDLE:
            begin
               if (cmd_take)
               begin
                  body_after_q <= 1'b0;
                  cp_q <= '0;
                  cp_slot_q <= slot_idx;
                  cp_exec_q <= 1'b0;
                  cp_save_q <= 1'b0;
                  if (cmd_code_i == `PSU_CMD_QUEUE_SAVE && param_ok)
                  begin
                     cp_save_q <= 1'b1;
                     state_q <= PSU_COPY;
                  end
                  else if (cmd_code_i == `PSU_CMD_LOAD_EXEC && param_ok)
                  begin
                     cp_exec_q <= 1'b1;
                     state_q <= PSU_COPY;
                  end
                  else if (cmd_code_i == `PSU_CMD_QUEUE_LOAD && param_ok)
                  begin
                     state_q <= PSU_COPY;
                  end
                  else if (cmd_code_i == `PSU_CMD_QUEUE_EXEC
                     || (cmd_code_i == `PSU_CMD_QUEUE_LOAD && !cmd_has_param_i))
                  begin
                     state_q <= PSU_IDLE;
                  end
                  else if (cmd_code_i == `PSU_CMD_UPLOAD && prog_running_i)
                  begin
                     msg_q <= err_msg(`PSU_CHAR_ZERO + 8'h01);
                     msg_len_q <= 3'h6;
                     state_q <= PSU_MSG;
                  end
                  else if (cmd_code_i == `PSU_CMD_UPLOAD && protect_i)
                  begin
                     msg_q <= err_msg(`PSU_CHAR_ZERO + 8'h03);
                     msg_len_q <= 3'h6;
                     state_q <= PSU_MSG;
                  end
                  else if (cmd_code_i == `PSU_CMD_UPLOAD && cmd_has_param_i
                     && (param_ok || cmd_param_i == 8'h00))
                  begin
                     state_q <= PSU_MSG;
                     if (sel_len == 6'h00)
                     begin
                        msg_q <= {`PSU_CHAR_ACK, `PSU_CHAR_Q, `PSU_CHAR_U, `PSU_CHAR_ZERO,
                           `PSU_CHAR_CR, 8'h00};
                        msg_len_q <= 3'h5;
                     end
                     else
                     begin
                        body_after_q <= 1'b1;
                        up_sel_q <= (cmd_param_i == 8'h00) ? 4'h0 : cmd_param_i[3:0];
                        up_len_q <= sel_len;
                        ln_q <= '0;
                        bi_q <= '0;
                        if (hdr_n >= 7'h0A)
                        begin
                           msg_q <= {`PSU_CHAR_ACK, `PSU_CHAR_Q, `PSU_CHAR_U,
                              `PSU_CHAR_ZERO + 8'(hdr_n / 7'h0A),
                              `PSU_CHAR_ZERO + 8'(hdr_n % 7'h0A), `PSU_CHAR_CR};
                           msg_len_q <= 3'h6;
                        end
                        else
                        begin
                           msg_q <= {`PSU_CHAR_ACK, `PSU_CHAR_Q, `PSU_CHAR_U,
                              `PSU_CHAR_ZERO + 8'(hdr_n), `PSU_CHAR_CR, 8'h00};
                           msg_len_q <= 3'h5;
                        end
                     end
                  end
                  else
                  begin
                     // unknown code, missing or bad location: no state is touched
                     msg_q <= {`PSU_CHAR_NACK, `PSU_CHAR_CR, 32'h0};
                     msg_len_q <= 3'h2;
                     state_q <= PSU_MSG;
                  end
               end
            end
            PSU_COPY:
            begin
               cp_q <= cp_q + 6'h01;
               if (cp_q == `PSU_LAST_LINE)
               begin
                  state_q <= PSU_IDLE;
               end
            end
            PSU_MSG:
            begin
               if (emit_go)
               begin
                  msg_q <= {msg_q[39:0], 8'h00};
                  msg_len_q <= msg_len_q - 3'h1;
                  if (msg_len_q == 3'h1)
                  begin
                     state_q <= body_after_q ? PSU_BODY : PSU_IDLE;
                  end
               end
            end
            PSU_BODY:
            begin
               if (emit_go)
               begin
                  bi_q <= (bi_q == 3'h4) ? 3'h0 : bi_q + 3'h1;
                  if (bi_q == 3'h4)
                  begin
                     ln_q <= ln_q + 6'h01;
                  end
                  if (body_end)
                  begin
                     state_q <= PSU_DONE;
                  end
               end
            end
            PSU_DONE:
            begin
               // a refused second upload answers once the first has drained
               body_after_q <= 1'b0;
               if (pend_busy_q)
               begin
                  msg_q <= err_msg(`PSU_CHAR_ZERO + 8'h02);
                  msg_len_q <= 3'h6;
                  state_q <= PSU_MSG;
               end
               else
               begin
                  state_q <= PSU_IDLE;
               end
            end
         endcase
      end
   end

   // an upload arriving while another runs is held for its refusal
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pend_busy_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (cmd_take && state_q != PSU_IDLE)
         begin
            pend_busy_q <= 1'b1;
         end
         else if (state_q == PSU_DONE)
         begin
            pend_busy_q <= 1'b0;
         end
      end
   end

   // segment and queue storage, no reset as in a real memory
   always_ff @(posedge ref_clk_i)
   begin
      if (ce_i)
      begin
         if (state_q == PSU_COPY && cp_save_q)
         begin
            slot_mem_q[cp_slot_q][cp_q] <= q_mem_q[cp_q];
         end
         else if (state_q == PSU_COPY)
         begin
            q_mem_q[cp_q] <= slot_mem_q[cp_slot_q][cp_q];
         end
         else if (state_q == PSU_IDLE && load_active_q && line_valid_i
            && load_ptr_q != 6'(`PSU_LINES))
         begin
            q_mem_q[load_ptr_q] <= line_data_i;
         end
      end
   end

   // line counts, zero marks an empty slot
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q_len_q <= '0;
         for (int i = 0; i < `PSU_SLOTS; i++)
         begin
            slot_len_q[i] <= '0;
         end
      end
      else if (ce_i)
      begin
         if (state_q == PSU_COPY && cp_q == `PSU_LAST_LINE)
         begin
            if (cp_save_q)
            begin
               slot_len_q[cp_slot_q] <= q_len_q;
            end
            else
            begin
               q_len_q <= slot_len_q[cp_slot_q];
            end
         end
         else if (cmd_take && state_q == PSU_IDLE && cmd_code_i == `PSU_CMD_QUEUE_LOAD
            && !cmd_has_param_i)
         begin
            q_len_q <= '0;
         end
         else if (state_q == PSU_IDLE && load_active_q && line_valid_i
            && load_ptr_q != 6'(`PSU_LINES))
         begin
            q_len_q <= load_ptr_q + 6'h01;
         end
      end
   end

   // host load session
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         load_active_q <= 1'b0;
         load_ptr_q <= '0;
      end
      else if (ce_i)
      begin
         if (cmd_take && state_q == PSU_IDLE && cmd_code_i == `PSU_CMD_QUEUE_LOAD
            && !cmd_has_param_i)
         begin
            load_active_q <= 1'b1;
            load_ptr_q <= '0;
         end
         // a save refused for its location leaves the session open
         else if (cmd_take && state_q == PSU_IDLE && ((cmd_code_i == `PSU_CMD_QUEUE_SAVE
            && param_ok) || cmd_code_i == `PSU_CMD_QUEUE_EXEC))
         begin
            load_active_q <= 1'b0;
         end
         else if (state_q == PSU_IDLE && load_active_q && line_valid_i
            && load_ptr_q != 6'(`PSU_LINES))
         begin
            load_ptr_q <= load_ptr_q + 6'h01;
         end
      end
   end

   // execution start toward the queue runner
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         exec_start_q <= 1'b0;
         exec_line_q <= `PSU_EXEC_LINE;
      end
      else if (ce_i)
      begin
         exec_start_q <= (state_q == PSU_COPY && cp_q == `PSU_LAST_LINE && cp_exec_q)
            || (cmd_take && state_q == PSU_IDLE
               && cmd_code_i == `PSU_CMD_QUEUE_EXEC);
      end
   end

   assign load_active_o = load_active_q;
   assign exec_start_o = exec_start_q;
   assign exec_line_o = exec_line_q;
endmodule // psu_top

`default_nettype wire

/* File: test/psu_top_properties.sv */
// port-level checker for the segment store and upload block
`default_nettype none
module psu_top_checker (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic ce_i, // clock enable
   input wire logic cmd_valid_i, // command present
   input wire logic cmd_ready_o, // command taken
   input wire logic [2:0] cmd_code_i, // command code
   input wire logic cmd_has_param_i, // location given
   input wire logic [7:0] cmd_param_i, // location
   input wire logic line_valid_i, // queue line
   input wire logic [31:0] line_data_i, // line text
   input wire logic prog_running_i, // program running
   input wire logic protect_i, // password lock
   input wire logic tx_valid_o, // reply char ready
   input wire logic tx_ready_i, // port takes char
   input wire logic [7:0] tx_data_o, // reply char
   input wire logic load_active_o, // load session open
   input wire logic exec_start_o, // start pulse
   input wire logic [5:0] exec_line_o // start line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take;
   logic slot_ok;
   logic bad;
   assign take = cmd_valid_i && cmd_ready_o && ce_i;
   assign slot_ok = cmd_has_param_i && cmd_param_i >= 8'h01 && cmd_param_i <= 8'h0C;
   // queue load with a location is left out: its reply is not fixed
   assign bad = take && (cmd_code_i == 3'h0 || cmd_code_i > 3'h5
      || ((cmd_code_i == 3'h2 || cmd_code_i == 3'h4) && !slot_ok)
      || (cmd_code_i == 3'h3 && !slot_ok && !(cmd_has_param_i && cmd_param_i == 8'h00)));
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // quiet span keeps a deferred reply from an earlier upload out of view
   sequence s_quiet;
      (!tx_valid_o && !take) [*8];
   endsequence
   sequence s_reply(logic [7:0] ch);
      ##[1:3] (tx_valid_o && tx_data_o == ch);
   endsequence
   property p_nack;
      s_quiet ##1 bad |-> s_reply(8'h3F);
   endproperty
   property p_ack;
      s_quiet ##1 (take && cmd_code_i == 3'h3 && !bad) |-> s_reply(8'h25);
   endproperty
   property p_copy_busy;
      take && cmd_code_i == 3'h2 && slot_ok |=> !cmd_ready_o [*8];
   endproperty
   property p_save_end;
      take && cmd_code_i == 3'h2 && slot_ok |-> ##[1:64] !load_active_o;
   endproperty
   property p_ldx;
      take && cmd_code_i == 3'h4 && slot_ok |-> ##63 exec_start_o;
   endproperty
   property p_qexec;
      take && cmd_code_i == 3'h5 |=> exec_start_o ##[0:2] !load_active_o;
   endproperty
   property p_pulse;
      exec_start_o |-> exec_line_o == 6'h01 ##1 !exec_start_o;
   endproperty
   property p_load_open;
      $rose(load_active_o) |-> $past(take && cmd_code_i == 3'h1 && !cmd_has_param_i);
   endproperty
   property p_bad_keep;
      bad && load_active_o |=> load_active_o;
   endproperty
   a_nack: assert property (p_nack) else $error("nack reply missing");
   a_ack: assert property (p_ack) else $error("upload reply lacks ack");
   a_copy_busy: assert property (p_copy_busy) else $error("save not copying");
   a_save_end: assert property (p_save_end) else $error("save left session open");
   a_ldx: assert property (p_ldx) else $error("load and execute no start");
   a_qexec: assert property (p_qexec) else $error("queue execute wrong");
   a_pulse: assert property (p_pulse) else $error("start pulse wrong");
   a_load_open: assert property (p_load_open) else $error("session opened wrongly");
   a_bad_keep: assert property (p_bad_keep) else $error("bad command changed state");
endmodule // psu_top_checker
bind psu_top psu_top_checker i_psu_top_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
   .cmd_code_i(cmd_code_i), .cmd_has_param_i(cmd_has_param_i), .cmd_param_i(cmd_param_i),
   .line_valid_i(line_valid_i), .line_data_i(line_data_i), .prog_running_i(prog_running_i),
   .protect_i(protect_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .tx_data_o(tx_data_o), .load_active_o(load_active_o), .exec_start_o(exec_start_o),
   .exec_line_o(exec_line_o));
`default_nettype wire

/* File: test/psu_host_model.sv */
// serial host model that takes reply characters
`default_nettype none
module psu_host_model (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic slow_i, // take one char in four
   input wire logic tx_valid_i, // reply char ready
   input wire logic [7:0] tx_data_i, // reply char
   output logic tx_ready_o // char taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q;
   logic [7:0] rx_q[$];
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         phase_q <= 2'h0;
      else
         phase_q <= phase_q + 2'h1;
   end
   // a slow host stalls three cycles in four so the reply fifo fills up
   assign tx_ready_o = !slow_i || phase_q == 2'h3;
   always @(posedge clk_i)
   begin
      if (rst_n_i && tx_valid_i && tx_ready_o)
         rx_q.push_back(tx_data_i);
   end
endmodule // psu_host_model
`default_nettype wire

/* File: test/tb_psu_top.sv */
// self-checking bench for the segment store and upload block
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_psu_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_code = 3'h0;
   logic cmd_has = 1'b0;
   logic [7:0] cmd_param = 8'h00;
   logic line_valid = 1'b0;
   logic [31:0] line_data = 32'h0;
   logic running = 1'b0;
   logic protect = 1'b0;
   logic slow = 1'b0;
   logic ce = 1'b1;
   logic cmd_ready, tx_valid, tx_ready, load_active, exec_start;
   logic [7:0] tx_data;
   logic [5:0] exec_line;
   int n_fail = 0;
   int comparisons = 0;
   psu_top i_psu_top (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_code_i(cmd_code),
      .cmd_has_param_i(cmd_has), .cmd_param_i(cmd_param), .line_valid_i(line_valid),
      .line_data_i(line_data), .prog_running_i(running), .protect_i(protect),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
      .load_active_o(load_active), .exec_start_o(exec_start), .exec_line_o(exec_line));
   psu_host_model i_psu_host_model (.clk_i(ref_clk), .rst_n_i(rst_n), .slow_i(slow),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic cmd(input logic [2:0] c, input logic h, input logic [7:0] p);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_has <= h;
      cmd_param <= p;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 300)
      begin
         n++;
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
   endtask
   task automatic line(input logic [31:0] d);
      @(posedge ref_clk);
      line_valid <= 1'b1;
      line_data <= d;
      @(posedge ref_clk);
      line_valid <= 1'b0;
   endtask
   // the idle tail also proves that no extra characters follow
   task automatic expect_str(input string nm, input string s);
      int n;
      logic [7:0] b;
      n = 0;
      while (i_psu_host_model.rx_q.size() < s.len() && n < 3000)
      begin
         n++;
         @(posedge ref_clk);
      end
      repeat (12) @(posedge ref_clk);
      for (int k = 0; k < s.len(); k++)
      begin
         b = i_psu_host_model.rx_q.size() > 0 ? i_psu_host_model.rx_q.pop_front() : 8'hXX;
         `CHK(nm, s[k], b)
      end
      `CHK(nm, 0, i_psu_host_model.rx_q.size())
   endtask
   task automatic wait_exec(input string nm);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (exec_start !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge ref_clk);
      end
      `CHK(nm, 1'b1, exec_start)
      `CHK(nm, 6'h01, exec_line)
   endtask
   task automatic t_nack();
      cmd(3'h7, 1'b0, 8'h00);
      expect_str("unknown code", "?\015");
      cmd(3'h3, 1'b0, 8'h00);
      expect_str("upload no location", "?\015");
      cmd(3'h3, 1'b1, 8'h0D);
      expect_str("upload location 13", "?\015");
      cmd(3'h2, 1'b1, 8'h00);
      expect_str("save location 0", "?\015");
      cmd(3'h3, 1'b1, 8'h05);
      expect_str("upload empty slot", "%QU0\015");
      $display("test nack done");
   endtask
   task automatic t_store();
      cmd(3'h1, 1'b0, 8'h00);
      @(negedge ref_clk);
      `CHK("session open", 1'b1, load_active)
      line(32'h41420000);
      line(32'h31323334);
      cmd(3'h2, 1'b1, 8'hFF);
      expect_str("save location -1", "?\015");
      `CHK("session kept", 1'b1, load_active)
      cmd(3'h2, 1'b1, 8'h0C);
      // clock enable low must hold the copy where it stands
      ce <= 1'b0;
      repeat (80) @(posedge ref_clk);
      `CHK("copy frozen", 1'b0, cmd_ready)
      ce <= 1'b1;
      repeat (70) @(posedge ref_clk);
      `CHK("session closed", 1'b0, load_active)
      cmd(3'h3, 1'b1, 8'h0C);
      expect_str("upload slot 12", "%QU3\015AB\0151234\015");
      cmd(3'h3, 1'b1, 8'h00);
      expect_str("upload queue", "%QU3\015AB\0151234\015");
      $display("test store done");
   endtask
   task automatic t_refuse();
      running <= 1'b1;
      protect <= 1'b1;
      cmd(3'h3, 1'b1, 8'h0C);
      expect_str("running and locked", "%QU-1\015");
      running <= 1'b0;
      cmd(3'h3, 1'b1, 8'h0C);
      expect_str("locked", "%QU-3\015");
      protect <= 1'b0;
      slow <= 1'b1;
      cmd(3'h3, 1'b1, 8'h0C);
      cmd(3'h3, 1'b1, 8'h0C);
      expect_str("upload while busy", "%QU3\015AB\0151234\015%QU-2\015");
      slow <= 1'b0;
      $display("test refuse done");
   endtask
   task automatic t_exec();
      cmd(3'h1, 1'b0, 8'h00);
      line(32'h5A5A0000);
      cmd(3'h5, 1'b0, 8'h00);
      wait_exec("queue execute");
      repeat (3) @(negedge ref_clk);
      `CHK("session ended", 1'b0, load_active)
      cmd(3'h3, 1'b1, 8'h00);
      expect_str("queue overwritten", "%QU2\015ZZ\015");
      running <= 1'b1;
      cmd(3'h4, 1'b1, 8'h0C);
      wait_exec("load and execute");
      @(posedge ref_clk);
      running <= 1'b0;
      cmd(3'h3, 1'b1, 8'h00);
      expect_str("queue from slot", "%QU3\015AB\0151234\015");
      cmd(3'h4, 1'b1, 8'h0D);
      expect_str("load and execute 13", "?\015");
      $display("test exec done");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_nack();
      t_store();
      t_refuse();
      t_exec();
      end_of_test();
   end
   // the tests need some six hundred cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      end_of_test();
   end
endmodule // tb_psu_top
`default_nettype wire
